// file: ewd_pkg.sv
package ewd_pkg;

	// ****************************************
	// Time base
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SEC_TIME_NS   = 1_000_000_000;
	localparam int unsigned SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;

	// ****************************************
	// Limits, in seconds
	// ****************************************
	localparam int unsigned SEC_W         = 10;
	localparam logic [9:0]  DELAY_MIN_S   = 10'h000;
	localparam logic [9:0]  DELAY_MAX_S   = 10'h258;
	localparam logic [9:0]  TMO_MIN_S     = 10'h014;
	localparam logic [9:0]  TMO_MAX_S     = 10'h258;
	localparam logic [9:0]  PRESS_SHORT_S = 10'h001;
	localparam logic [9:0]  PRESS_LONG_S  = 10'h004;

	// Reset pulse length on expiry, in clock cycles
	localparam logic [3:0]  RST_HOLD_CYCLES = 4'h8;

	typedef enum logic [1:0] {
		ACT_RESET,
		ACT_PRESS_SHORT,
		ACT_PRESS_LONG
	} ewd_action_type;

	// Bring a setting into its legal range
	function automatic logic [9:0] ewd_clamp(input logic [9:0] value,
		input logic [9:0] low, input logic [9:0] high);
		logic [9:0] result;
		result = value;
		if (value < low) begin
			result = low;
		end else if (value > high) begin
			result = high;
		end
		return result;
	endfunction : ewd_clamp

endpackage : ewd_pkg

// file: ewd_sec_tick.sv
module ewd_sec_tick
	import ewd_pkg::*;
#(
	parameter int unsigned CYCLES = SEC_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic restart,
	output logic      tick
);

	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_tick;

	// Restart zeroes the phase so a fresh second is always a full second
	always_comb begin
		next_count = count + CW'(1);
		next_tick  = 1'b0;
		if (restart) begin
			next_count = '0;
		end else if (count == LAST) begin
			next_count = '0;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

endmodule : ewd_sec_tick

// file: ewd_watchdog.sv
// Behaviour
// R1: While disabled, the delay and timeout do not count and no expiry action is started.
// R2: One of three expiry actions is selected and performed on expiry.
// R3: Reset action drives a whole-module reset pulse on expiry.
// R4: Short press action holds the power button for one second.
// R5: Long press action holds the power button for four seconds.
// R6: After enabling, wait a start delay of 0 to 600 seconds.
// R7: Timeout of 20 to 600 whole seconds runs until the action fires.
// R8: Host services the watchdog; each service reloads the full timeout.
module ewd_watchdog
	import ewd_pkg::*;
#(
	parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        wdt_enable,
	input  wire logic [1:0]  action_sel,
	input  wire logic [9:0]  start_delay,
	input  wire logic [9:0]  timeout,
	input  wire logic        service,
	output logic             wdt_reset,
	output logic             pwr_button_press,
	output logic             delaying,
	output logic             active,
	output logic [9:0]       remaining
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DELAY,
		ST_COUNT,
		ST_ACTION
	} ewd_state_type;

	ewd_state_type  state;
	ewd_state_type  next_state;
	ewd_action_type act;
	ewd_action_type next_act;
	logic [9:0]     next_remaining;
	logic [3:0]     hold;
	logic [3:0]     next_hold;
	logic           next_wdt_reset;
	logic           next_pwr_button_press;
	logic           next_delaying;
	logic           next_active;
	logic           restart;
	logic           tick;
	logic [9:0]     delay_s;
	logic [9:0]     tmo_s;
	ewd_action_type sel_act;

	ewd_sec_tick #(
		.CYCLES (SEC_CYCLES_P)
	) u_tick (
		.ref_clk (ref_clk),
		.reset   (reset),
		.restart (restart),
		.tick    (tick)
	);

	assign delay_s = ewd_clamp(start_delay, DELAY_MIN_S, DELAY_MAX_S);
	assign tmo_s   = ewd_clamp(timeout, TMO_MIN_S, TMO_MAX_S);
	// Unused code 3 falls back to reset, the safest recovery
	assign sel_act = (action_sel == 2'h1) ? ACT_PRESS_SHORT :
		(action_sel == 2'h2) ? ACT_PRESS_LONG : ACT_RESET;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		next_state     = state;
		next_remaining = remaining;
		next_hold      = hold;
		next_act       = act;
		restart        = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (wdt_enable) begin
					restart = 1'b1;
					if (delay_s == 10'h000) begin
						next_state     = ST_COUNT;
						next_remaining = tmo_s; // R7
					end else begin
						next_state     = ST_DELAY;
						next_remaining = delay_s; // R6
					end
				end
			end
			ST_DELAY: begin
				if (!wdt_enable) begin
					next_state     = ST_IDLE; // R1
					next_remaining = 10'h000;
				end else if (tick) begin
					if (remaining == 10'h001) begin
						next_state     = ST_COUNT;
						next_remaining = tmo_s; // R7
					end else begin
						next_remaining = remaining - 10'h001; // R6
					end
				end
			end
			ST_COUNT: begin
				if (!wdt_enable) begin
					next_state     = ST_IDLE; // R1
					next_remaining = 10'h000;
				end else if (service) begin
					// Service beats a tick landing in the same cycle
					next_remaining = tmo_s; // R8
					restart        = 1'b1;
				end else if (tick) begin
					if (remaining == 10'h001) begin
						next_state = ST_ACTION; // R2
						next_act   = sel_act;
						next_hold  = RST_HOLD_CYCLES; // R3
						next_remaining = (sel_act == ACT_PRESS_LONG) ? PRESS_LONG_S : PRESS_SHORT_S; // R4 R5
					end else begin
						next_remaining = remaining - 10'h001; // R7
					end
				end
			end
			ST_ACTION: begin
				// An action in progress always completes, even if disabled
				if (act == ACT_RESET) begin
					if (hold == 4'h1) begin
						next_state     = ST_IDLE;
						next_remaining = 10'h000;
					end else begin
						next_hold = hold - 4'h1; // R3
					end
				end else if (tick) begin
					if (remaining == 10'h001) begin
						next_state     = ST_IDLE;
						next_remaining = 10'h000;
					end else begin
						next_remaining = remaining - 10'h001; // R5
					end
				end
			end
		endcase
	end

	always_comb begin
		next_delaying         = (next_state == ST_DELAY);
		next_active           = (next_state == ST_COUNT);
		next_wdt_reset        = (next_state == ST_ACTION) && (next_act == ACT_RESET); // R3
		next_pwr_button_press = (next_state == ST_ACTION) && (next_act != ACT_RESET); // R4 R5
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state            <= ST_IDLE;
			act              <= ACT_RESET;
			hold             <= 4'h0;
			remaining        <= 10'h000;
			delaying         <= 1'b0;
			active           <= 1'b0;
			wdt_reset        <= 1'b0;
			pwr_button_press <= 1'b0;
		end else begin
			state            <= next_state;
			act              <= next_act;
			hold             <= next_hold;
			remaining        <= next_remaining;
			delaying         <= next_delaying;
			active           <= next_active;
			wdt_reset        <= next_wdt_reset;
			pwr_button_press <= next_pwr_button_press;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Helper: length of the current press in cycles
	logic [31:0] press_len;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			press_len <= 32'h0000_0000;
		end else if (pwr_button_press) begin
			press_len <= press_len + 32'h0000_0001;
		end else begin
			press_len <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_disabled_quiet: assert property ( // R1
		(!wdt_enable && state != ST_ACTION) |=> (!active && !delaying && !wdt_reset && !pwr_button_press))
		else $error("watchdog ran while disabled");

	a_delay_load: assert property ( // R6
		$rose(delaying) |-> (remaining == ewd_clamp($past(start_delay), DELAY_MIN_S, DELAY_MAX_S)))
		else $error("start delay loaded wrong");

	a_delay_range: assert property ( // R6
		delaying |-> (remaining >= 10'h001 && remaining <= DELAY_MAX_S))
		else $error("start delay out of range");

	a_timeout_load: assert property ( // R7
		$rose(active) |-> (remaining == ewd_clamp($past(timeout), TMO_MIN_S, TMO_MAX_S)))
		else $error("timeout loaded wrong");

	a_service_reload: assert property ( // R8
		(state == ST_COUNT && wdt_enable && service) |=>
			(active && remaining == ewd_clamp($past(timeout), TMO_MIN_S, TMO_MAX_S)))
		else $error("service did not reload timeout");

	a_expiry_fires: assert property ( // R2
		(state == ST_COUNT && wdt_enable && !service && tick && remaining == 10'h001) |=>
			(state == ST_ACTION && (wdt_reset != pwr_button_press) && !active))
		else $error("expiry did not start the action");

	a_reset_width: assert property ( // R3
		$rose(wdt_reset) |-> (wdt_reset && act == ACT_RESET)[*8] ##1 !wdt_reset)
		else $error("reset pulse has wrong length");

	a_press_short: assert property ( // R4
		($fell(pwr_button_press) && act == ACT_PRESS_SHORT) |-> (press_len == SEC_CYCLES_P))
		else $error("short press has wrong length");

	a_press_long: assert property ( // R5
		($fell(pwr_button_press) && act == ACT_PRESS_LONG) |-> (press_len == 4 * SEC_CYCLES_P))
		else $error("long press has wrong length");

	c_service: cover property (active && service);
	c_reset_action: cover property ($rose(wdt_reset));
	c_press_long: cover property ($fell(pwr_button_press) && act == ACT_PRESS_LONG);
	c_no_delay: cover property ($rose(active) && $past(state) == ST_IDLE);

endmodule : ewd_watchdog

// file: ewd_tb.sv
module tb
	import ewd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Short second keeps the run small
	// ****************************************
	localparam int SP = 10;

	logic       ref_clk;
	logic       reset;
	logic       wdt_enable;
	logic [1:0] action_sel;
	logic [9:0] start_delay;
	logic [9:0] timeout;
	logic       service;
	logic       wdt_reset;
	logic       pwr_button_press;
	logic       delaying;
	logic       active;
	logic [9:0] remaining;
	int         failures;
	int         tests_run;
	int         cycles;
	int         n;
	int         exp_len;

	ewd_watchdog #(
		.SEC_CYCLES_P(SP)
	) uut (
		.ref_clk         (ref_clk),
		.reset           (reset),
		.wdt_enable      (wdt_enable),
		.action_sel      (action_sel),
		.start_delay     (start_delay),
		.timeout         (timeout),
		.service         (service),
		.wdt_reset       (wdt_reset),
		.pwr_button_press(pwr_button_press),
		.delaying        (delaying),
		.active          (active),
		.remaining       (remaining)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Hang guard, far above the expected thousand or so cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("BAD run_length expected below 20000 seen %0d", cycles);
			stop_test();
		end
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic step(input int k);
		repeat (k) begin
			@(posedge ref_clk);
			#10;
		end
	endtask : step

	function automatic logic sig(input int w);
		case (w)
			0: sig = wdt_reset;
			1: sig = pwr_button_press;
			2: sig = delaying;
			default: sig = active;
		endcase
	endfunction : sig

	task automatic wait_high(input int w, input int limit, output int k);
		k = 0;
		while (sig(w) !== 1'b1 && k < limit) begin
			step(1);
			k++;
		end
	endtask : wait_high

	task automatic high_len(input int w, output int k);
		k = 0;
		while (sig(w) === 1'b1 && k < 100) begin
			step(1);
			k++;
		end
	endtask : high_len

	task automatic check_val(input string name, input logic [9:0] exp, input logic [9:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check_val

	task automatic check_rng(input string name, input int lo, input int hi, input int got);
		tests_run++;
		if (got < lo || got > hi) begin
			failures++;
			$display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask : check_rng

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		failures = 0;
		tests_run = 0;
		cycles = 0;
		reset = 1'b1;
		wdt_enable = 1'b0;
		action_sel = 2'h0;
		start_delay = 10'h000;
		timeout = 10'h014;
		service = 1'b0;
		step(12);
		reset = 1'b0;
		repeat (5) begin
			service = 1'b1;
			step(1);
			service = 1'b0;
			step(9);
		end
		check_val("status", 10'h000, {6'h00, delaying, active, wdt_reset, pwr_button_press});
		check_val("remaining", 10'h000, remaining);
		$display("test disabled done");

		start_delay = 10'h002;
		wdt_enable = 1'b1;
		step(2);
		check_val("delaying", 10'h001, {9'h000, delaying});
		check_val("remaining", 10'h002, remaining);
		wait_high(3, 4 * SP, n);
		check_rng("delay_cycles", 2 * SP, 2 * SP + 3, n + 2);
		check_val("remaining", 10'h014, remaining);
		step(5 * SP);
		service = 1'b1;
		step(1);
		service = 1'b0;
		step(1);
		check_val("reloaded", 10'h014, remaining);
		wait_high(0, 25 * SP, n);
		check_rng("expiry_cycles", 20 * SP - 2, 20 * SP + 3, n + 1);
		wdt_enable = 1'b0;
		// Disabling mid-action must not cut the pulse short
		high_len(0, n);
		check_rng("reset_pulse", 8, 8, n);
		step(3);
		check_val("idle", 10'h000, {8'h00, delaying, active});
		$display("test reset action done");

		for (int a = 1; a <= 3; a++) begin
			action_sel = a[1:0];
			start_delay = 10'h000;
			timeout = 10'h005;
			wdt_enable = 1'b1;
			step(2);
			check_val("active", 10'h001, {9'h000, active});
			check_val("remaining", 10'h014, remaining);
			wait_high((a == 3) ? 0 : 1, 25 * SP, n);
			check_rng("expiry_cycles", 20 * SP - 2, 20 * SP + 3, n + 1);
			if (a < 3) begin
				check_val("press_secs", (a == 1) ? 10'h001 : 10'h004, remaining);
			end
			wdt_enable = 1'b0;
			high_len((a == 3) ? 0 : 1, n);
			exp_len = (a == 1) ? SP : ((a == 2) ? 4 * SP : int'(RST_HOLD_CYCLES));
			check_rng("action_len", exp_len, exp_len, n);
			step(3);
		end
		$display("test action select done");

		start_delay = 10'h3FF;
		wdt_enable = 1'b1;
		step(2);
		check_val("delay_max", 10'h258, remaining);
		wdt_enable = 1'b0;
		step(2);
		check_val("stopped", 10'h000, {8'h00, delaying, active});
		// Over-long timeout is held at the ceiling; disabling mid-count stops it
		start_delay = 10'h000;
		timeout = 10'h3FF;
		wdt_enable = 1'b1;
		step(2);
		check_val("timeout_max", 10'h258, remaining);
		check_val("counting", 10'h001, {9'h000, active});
		wdt_enable = 1'b0;
		step(2);
		check_val("count_stopped", 10'h000, {8'h00, delaying, active});
		check_val("count_cleared", 10'h000, remaining);
		$display("test delay limit done");
		stop_test();
	end

endmodule : tb
